// File: sdac_decode.sv
// six-byte direct-access command decoder and executor
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sdac_params.svh"
module sdac_decode
    import sdac_pkg::*;
#(
    parameter int LBA_W = 21                    // logical block address width
) (
    input  wire logic        core_clk_i,        // 200 MHz system clock
    input  wire logic        srst_i,            // synchronous reset, high
    input  wire logic        cmd_valid_i,       // one-cycle command byte strobe
    input  wire logic [7:0]  cmd_byte_i,        // command block byte
    input  wire logic        resv_conflict_i,   // reservation conflict level
    input  wire logic        unit_attn_i,       // reset or medium change pulse
    input  wire logic        rd_err_i,          // unrecoverable medium read error
    input  wire logic        rd_recov_i,        // recovered read error
    input  wire logic        abort_i,           // overrun or retryable error
    input  wire logic        dout_valid_i,      // data out byte from initiator
    input  wire logic [7:0]  dout_byte_i,       // data out byte value
    output logic             dout_ready_o,      // target takes data out bytes
    input  wire logic        blk_done_i,        // media finished one block
    output sdac_blk_type     blk_o,             // block request to the media
    output logic             stat_valid_o,      // status byte strobe
    output logic [7:0]       stat_byte_o,       // status byte
    output logic             linked_o,          // link bit of ending command
    output logic             flag_o,            // flag bit of ending command
    input  wire logic        stat_ack_i,        // status taken
    input  wire logic [3:0]  reg_addr_i,        // register address
    input  wire logic [31:0] reg_wdata_i,       // register write data
    input  wire logic        reg_wr_i,          // register write strobe
    input  wire logic        reg_rd_i,          // register read strobe
    output logic [31:0]      reg_rdata_o        // read data, one cycle later
);

    // opcode classification used by decode and by the error checks
    function automatic logic sdac_is_xfer(input logic [7:0] op);
        return (op == `SDAC_OP_READ) || (op == `SDAC_OP_WRITE);
    endfunction : sdac_is_xfer

    function automatic logic sdac_known(input logic [7:0] op);
        return sdac_is_xfer(op) || (op == `SDAC_OP_SEEK) || (op == `SDAC_OP_MSEL);
    endfunction : sdac_known

    sdac_state_type    state_q, state_d;
    logic [47:0]       shreg_q, shreg_d;
    logic [2:0]        bcnt_q, bcnt_d;
    sdac_cdb_type      cdb_q, cdb_d;
    logic [8:0]        left_q, left_d;
    logic [LBA_W-1:0]  cur_q, cur_d;
    logic              busy_q, busy_d;
    logic [7:0]        plen_q, plen_d;
    logic [7:0]        pidx_q, pidx_d;
    logic [7:0]        bdlen_q, bdlen_d;
    logic [7:0]        medium_q, medium_d;
    logic [7:0]        status_q, status_d;
    logic [3:0]        sense_q, sense_d;
    logic [LBA_W-1:0]  info_q, info_d;
    logic [LBA_W-1:0]  cap_q, cap_d;
    logic              ua_q, ua_d;
    logic              fin_q, fin_d;
    logic [31:0]       rdata_q, rdata_d;
    sdac_cdb_type      cdb_w;
    logic [LBA_W:0]    end_w;

    // assemble the six bytes into named fields
    always_comb begin
        cdb_w.opcode = shreg_q[47:40];
        cdb_w.lun    = shreg_q[39:37];
        cdb_w.lba    = shreg_q[36:16];
        cdb_w.length = shreg_q[15:8];
        cdb_w.vendor = shreg_q[7:6];
        cdb_w.flag   = shreg_q[1];
        cdb_w.link   = shreg_q[0];
    end

    // block after the last of the request, one bit wider to catch wrap past capacity
    assign end_w = {1'b0, cdb_w.lba} + {{(LBA_W-8){1'b0}},
                   (cdb_w.length == 8'h00) ? `SDAC_CNT_ZERO_LEN : {1'b0, cdb_w.length}};

    // command engine next state
    always_comb begin
        state_d  = state_q;
        shreg_d  = shreg_q;
        bcnt_d   = bcnt_q;
        cdb_d    = cdb_q;
        left_d   = left_q;
        cur_d    = cur_q;
        busy_d   = busy_q;
        plen_d   = plen_q;
        pidx_d   = pidx_q;
        bdlen_d  = bdlen_q;
        medium_d = medium_q;
        status_d = status_q;
        sense_d  = sense_q;
        info_d   = info_q;
        cap_d    = cap_q;
        fin_d    = 1'b0;
        // set wins over the clear done by the next command
        ua_d     = ua_q;
        case (state_q)
            SDAC_IDLE: begin
                if (cmd_valid_i) begin
                    shreg_d = {shreg_q[39:0], cmd_byte_i};
                    bcnt_d  = bcnt_q + 3'h1;
                end
                if (bcnt_q == 3'h6) begin
                    bcnt_d   = 3'h0;
                    cdb_d    = cdb_w;
                    status_d = `SDAC_ST_GOOD;
                    sense_d  = `SDAC_SK_NONE;
                    cur_d    = cdb_w.lba;
                    left_d   = (cdb_w.length == 8'h00) ? `SDAC_CNT_ZERO_LEN
                                                       : {1'b0, cdb_w.length};
                    state_d  = SDAC_STAT;
                    if (!sdac_known(cdb_w.opcode)) begin
                        status_d = `SDAC_ST_CHECK;
                        sense_d  = `SDAC_SK_ILLEGAL;
                    end else if (resv_conflict_i) begin
                        status_d = `SDAC_ST_RESV;
                    end else if (ua_q) begin
                        status_d = `SDAC_ST_CHECK;
                        sense_d  = `SDAC_SK_UNIT_ATTN;
                        ua_d     = unit_attn_i;
                    end else if ((sdac_is_xfer(cdb_w.opcode) && end_w > {1'b0, cap_q})
                                 || (cdb_w.opcode == `SDAC_OP_SEEK && cdb_w.lba >= cap_q)) begin
                        status_d = `SDAC_ST_CHECK;
                        sense_d  = `SDAC_SK_ILLEGAL;
                        info_d   = (cdb_w.lba >= cap_q) ? cdb_w.lba : cap_q;
                    end else if (sdac_is_xfer(cdb_w.opcode)) begin
                        state_d  = SDAC_XFER;
                    end else if (cdb_w.opcode == `SDAC_OP_MSEL) begin
                        plen_d   = cdb_w.length;
                        pidx_d   = 8'h00;
                        bdlen_d  = 8'h00;
                        medium_d = `SDAC_MEDIUM_DEFAULT;
                        state_d  = (cdb_w.length == 8'h00) ? SDAC_STAT : SDAC_MSEL;
                    end
                    // seek ends at once with good status, no data phase
                end
            end
            SDAC_XFER: begin
                if (rd_err_i || rd_recov_i || abort_i) begin
                    status_d = `SDAC_ST_CHECK;
                    sense_d  = abort_i ? `SDAC_SK_ABORTED :
                               rd_err_i ? `SDAC_SK_MEDIUM : `SDAC_SK_RECOVERED;
                    info_d   = cur_q;
                    busy_d   = 1'b0;
                    state_d  = SDAC_STAT;
                end else if (!busy_q) begin
                    busy_d = 1'b1;                         // one block in flight
                end else if (blk_done_i) begin
                    busy_d = 1'b0;
                    cur_d  = cur_q + {{(LBA_W-1){1'b0}}, 1'b1};
                    left_d = left_q - 9'h001;
                    if (left_q == 9'h001) begin
                        state_d = SDAC_STAT;
                    end
                end
            end
            SDAC_MSEL: begin
                if (dout_valid_i) begin
                    pidx_d = pidx_q + 8'h01;
                    // header first, then descriptors and vendor bytes
                    if (pidx_q == {6'h00, `SDAC_HDR_MEDIUM}) begin
                        medium_d = dout_byte_i;
                    end
                    if (pidx_q == {6'h00, `SDAC_HDR_BDLEN}) begin
                        bdlen_d = dout_byte_i;
                    end
                    if (pidx_q + 8'h01 == plen_q) begin
                        state_d = SDAC_STAT;
                    end
                end
            end
            SDAC_STAT: begin
                fin_d   = 1'b1;
                state_d = SDAC_WAIT;
            end
            SDAC_WAIT: begin
                if (stat_ack_i) begin
                    state_d = SDAC_IDLE;
                end
            end
            default: begin
                state_d = SDAC_IDLE;
            end
        endcase
        if (unit_attn_i) begin
            ua_d = 1'b1;
        end
        if (reg_wr_i && reg_addr_i == `SDAC_ADDR_CAPACITY) begin
            cap_d = reg_wdata_i[LBA_W-1:0];
        end
    end

    // read data mux, answered in the cycle after the strobe
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `SDAC_ADDR_CMD:      rdata_d = {24'h000000, cdb_q.opcode};
                `SDAC_ADDR_STATUS:   rdata_d = {18'h00000, ua_q, state_q, status_q};
                `SDAC_ADDR_SENSE:    rdata_d = {28'h0000000, sense_q};
                `SDAC_ADDR_INFO:     rdata_d = {{(32-LBA_W){1'b0}}, info_q};
                `SDAC_ADDR_MODE:     rdata_d = {16'h0000, bdlen_q, medium_q};
                `SDAC_ADDR_CAPACITY: rdata_d = {{(32-LBA_W){1'b0}}, cap_q};
                default:             rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // all state registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q  <= SDAC_IDLE;
            shreg_q  <= 48'h0;
            bcnt_q   <= 3'h0;
            cdb_q    <= '0;
            left_q   <= 9'h000;
            cur_q    <= '0;
            busy_q   <= 1'b0;
            plen_q   <= 8'h00;
            pidx_q   <= 8'h00;
            bdlen_q  <= 8'h00;
            medium_q <= `SDAC_MEDIUM_DEFAULT;
            status_q <= `SDAC_ST_GOOD;
            sense_q  <= `SDAC_SK_NONE;
            info_q   <= '0;
            cap_q    <= `SDAC_CAPACITY_RST;
            ua_q     <= 1'b1;                              // target reset counts
            fin_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            state_q  <= state_d;
            shreg_q  <= shreg_d;
            bcnt_q   <= bcnt_d;
            cdb_q    <= cdb_d;
            left_q   <= left_d;
            cur_q    <= cur_d;
            busy_q   <= busy_d;
            plen_q   <= plen_d;
            pidx_q   <= pidx_d;
            bdlen_q  <= bdlen_d;
            medium_q <= medium_d;
            status_q <= status_d;
            sense_q  <= sense_d;
            info_q   <= info_d;
            cap_q    <= cap_d;
            ua_q     <= ua_d;
            fin_q    <= fin_d;
            rdata_q  <= rdata_d;
        end
    end

    // outputs; block request only while a block is in flight
    always_comb begin
        blk_o.valid  = (state_q == SDAC_XFER) && busy_q;
        blk_o.write  = (cdb_q.opcode == `SDAC_OP_WRITE);
        blk_o.lba    = cur_q;
        dout_ready_o = (state_q == SDAC_MSEL);
        stat_valid_o = fin_q;
        stat_byte_o  = status_q;
        linked_o     = cdb_q.link;
        flag_o       = cdb_q.flag;
        reg_rdata_o  = rdata_q;
    end

    // decode cycle of a complete command, and the same with a known opcode, no reservation conflict and no unit attention pending;
    // only the checks below read these
    logic              dec_w;
    logic              clear_w;
    assign dec_w   = (state_q == SDAC_IDLE) && (bcnt_q == 3'h6);
    assign clear_w = dec_w && sdac_known(cdb_w.opcode) && !resv_conflict_i && !ua_q;

    // no media access may start after a command refused for a reservation conflict
    resv_no_media_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (dec_w && sdac_known(cdb_w.opcode) && resv_conflict_i)
        |=> (!blk_o.valid && state_q == SDAC_STAT && status_q == `SDAC_ST_RESV))
        else $error("media accessed under reservation conflict");

    illegal_info_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fin_q && sense_q == `SDAC_SK_ILLEGAL && sdac_is_xfer(cdb_q.opcode))
        |-> info_q >= cdb_q.lba)
        else $error("information bytes below request address");

    // block count, both the wrapped zero and the plain value
    zero_len_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_q == SDAC_IDLE && $past(state_q) == SDAC_IDLE && state_d == SDAC_XFER
         && cdb_w.length == 8'h00) |=> left_q == 9'h100)
        else $error("zero length not taken as 256 blocks");

    len_count_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (clear_w && sdac_is_xfer(cdb_w.opcode) && cdb_w.length != 8'h00)
        |=> left_q == {1'b0, $past(cdb_w.length)})
        else $error("block count differs from transfer length");

    msel_zero_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_d == SDAC_STAT && state_q == SDAC_IDLE && cdb_w.opcode == `SDAC_OP_MSEL
         && cdb_w.length == 8'h00 && status_d == `SDAC_ST_GOOD) |=> ##1 fin_q)
        else $error("empty parameter list not ended");

    ua_report_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (dec_w && sdac_known(cdb_w.opcode) && !resv_conflict_i && ua_q)
        |=> (status_q == `SDAC_ST_CHECK && sense_q == `SDAC_SK_UNIT_ATTN))
        else $error("unit attention without check condition");

    // a clean read or write opens at the command address, in the right direction
    xfer_start_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (clear_w && sdac_is_xfer(cdb_w.opcode) && end_w <= {1'b0, cap_q})
        |=> (state_q == SDAC_XFER && blk_o.lba == $past(cdb_w.lba)
             && blk_o.write == ($past(cdb_w.opcode) == `SDAC_OP_WRITE)))
        else $error("transfer not started at the command address");

    // out-of-range request is refused before any block is asked for
    bad_addr_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (clear_w && sdac_is_xfer(cdb_w.opcode) && end_w > {1'b0, cap_q})
        |=> (state_q == SDAC_STAT && sense_q == `SDAC_SK_ILLEGAL && !blk_o.valid))
        else $error("out-of-range transfer not refused");

    seek_nodata_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (dec_w && cdb_w.opcode == `SDAC_OP_SEEK) |=> state_q == SDAC_STAT)
        else $error("seek entered a data phase");

    blk_step_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (blk_o.valid && blk_done_i && !rd_err_i && !rd_recov_i && !abort_i
         && left_q != 9'h001) |=> ##1 (blk_o.lba == $past(cur_q, 2) + 1'b1))
        else $error("block address did not step by one");

    // parameter list phase: opened with the right length, medium type byte kept
    msel_entry_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (clear_w && cdb_w.opcode == `SDAC_OP_MSEL && cdb_w.length != 8'h00)
        |=> (dout_ready_o && plen_q == $past(cdb_w.length) && pidx_q == 8'h00))
        else $error("parameter list phase not opened");

    msel_count_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_q == SDAC_MSEL) |-> pidx_q < plen_q)
        else $error("parameter bytes beyond list length");

    medium_take_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_q == SDAC_MSEL && dout_valid_i && pidx_q == {6'h00, `SDAC_HDR_MEDIUM})
        |=> medium_q == $past(dout_byte_i))
        else $error("medium type byte not stored");

    // error keys in mid transfer; abort outranks a read error in one cycle
    err_key_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_q == SDAC_XFER && abort_i) |=> sense_q == `SDAC_SK_ABORTED)
        else $error("retryable error not reported as aborted");

    read_err_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (state_q == SDAC_XFER && rd_err_i && !abort_i) |=> sense_q == `SDAC_SK_MEDIUM)
        else $error("unrecoverable read error not reported");

endmodule : sdac_decode
`default_nettype wire

// File: sdac_media_model.sv
// media stand-in that completes the block requests of the decoder
`timescale 1ns/100ps
`default_nettype none
module sdac_media_model
    import sdac_pkg::*;
#(
    parameter int DELAY = 2                  // cycles a block takes on the media
) (
    input  wire logic         core_clk_i,    // system clock
    input  wire logic         clr_i,         // clear the tallies
    input  wire sdac_blk_type blk_i,         // block request from the decoder
    output logic              blk_done_o,    // one-cycle completion pulse
    output int                n_blk_o,       // blocks completed
    output int                n_wr_o,        // completed blocks that were writes
    output logic [20:0]       first_lba_o,   // address of the first block
    output logic [20:0]       last_lba_o     // address of the latest block
);
    int   cnt_q;
    logic armed_q;
    // one completion per request; re-armed only once valid has dropped,
    // so a request held a cycle too long is never counted twice
    always_ff @(posedge core_clk_i) begin
        blk_done_o <= 1'b0;
        if (clr_i) begin
            n_blk_o <= 0;
            n_wr_o  <= 0;
        end
        if (blk_i.valid !== 1'b1) begin
            cnt_q   <= 0;
            armed_q <= 1'b1;
        end else if (armed_q && cnt_q == DELAY) begin
            blk_done_o <= 1'b1;
            armed_q    <= 1'b0;
            n_blk_o    <= n_blk_o + 1;
            n_wr_o     <= n_wr_o + int'(blk_i.write);
            last_lba_o <= blk_i.lba;
            if (n_blk_o == 0) begin
                first_lba_o <= blk_i.lba;
            end
        end else if (armed_q) begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule : sdac_media_model
`default_nettype wire

// File: sdac_params.svh
// constants for the direct-access command decoder
`ifndef SDAC_PARAMS_SVH
`define SDAC_PARAMS_SVH
`define SDAC_OP_READ        8'h08
`define SDAC_OP_WRITE       8'h0A
`define SDAC_OP_SEEK        8'h0B
`define SDAC_OP_MSEL        8'h15
`define SDAC_CNT_ZERO_LEN   9'h100
`define SDAC_ST_GOOD        8'h00
`define SDAC_ST_CHECK       8'h02
`define SDAC_ST_RESV        8'h18
`define SDAC_SK_NONE        4'h0
`define SDAC_SK_RECOVERED   4'h1
`define SDAC_SK_MEDIUM      4'h3
`define SDAC_SK_ILLEGAL     4'h5
`define SDAC_SK_UNIT_ATTN   4'h6
`define SDAC_SK_ABORTED     4'hB
`define SDAC_HDR_MEDIUM     2'h1
`define SDAC_HDR_BDLEN      2'h3
`define SDAC_MEDIUM_DEFAULT 8'h00
`define SDAC_ADDR_CMD       4'h0
`define SDAC_ADDR_STATUS    4'h1
`define SDAC_ADDR_SENSE     4'h2
`define SDAC_ADDR_INFO      4'h3
`define SDAC_ADDR_MODE      4'h4
`define SDAC_ADDR_CAPACITY  4'h5
`define SDAC_CAPACITY_RST   21'h000100
`endif

// File: sdac_pkg.sv
// types for the direct-access command decoder
package sdac_pkg;
    typedef struct packed {
        logic [7:0]  opcode;
        logic [2:0]  lun;
        logic [20:0] lba;
        logic [7:0]  length;
        logic [1:0]  vendor;
        logic        flag;
        logic        link;
    } sdac_cdb_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [20:0] lba;
    } sdac_blk_type;

    typedef enum logic [4:0] {
        SDAC_IDLE  = 5'h01,
        SDAC_XFER  = 5'h02,
        SDAC_MSEL  = 5'h04,
        SDAC_STAT  = 5'h08,
        SDAC_WAIT  = 5'h10
    } sdac_state_type;
endpackage : sdac_pkg

// File: test_scsi_direct_access_cmd_decode.sv
// self-checking bench for the direct-access command decoder
`timescale 1ns/100ps
`default_nettype none
`include "sdac_params.svh"
module test_scsi_direct_access_cmd_decode;
    import sdac_pkg::*;
    typedef struct {
        logic [7:0]  op;
        logic [20:0] lba;
        logic [7:0]  len;
        logic [7:0]  st;
        logic [3:0]  sk;
        int          nb;
        int          nw;
    } sdac_row_type;
    logic clk = 0, srst = 1, cv = 0, rc = 0, ua = 0, dv = 0, bd, wr = 0, rd = 0, ack = 0, clr = 0;
    logic [2:0]   err = 3'h0;     // abort, medium, recovered
    logic [7:0]   cb = 8'h00, db = 8'h00, sb, s;
    logic [3:0]   ra = 4'h0;
    logic [31:0]  wd = 32'h0, rdat, d;
    logic [20:0]  flba, llba;
    sdac_blk_type blk;
    logic         sv, rdy, lk, fl;
    int           n_mismatch = 0, samples_checked = 0, cyc = 0, nb, nw, i, k;
    logic [7:0]   pl [12] = '{8'h00, `SDAC_MEDIUM_DEFAULT, 8'h00, 8'h08, 8'h01, 8'h00, 8'h01,
                              8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    // ordinary cases; first row meets the unit attention left by reset
    sdac_row_type rows [10] = '{
        '{`SDAC_OP_READ,  21'h000010, 8'h01, `SDAC_ST_CHECK, `SDAC_SK_UNIT_ATTN, 0, 0},
        '{`SDAC_OP_READ,  21'h000010, 8'h02, `SDAC_ST_GOOD,  `SDAC_SK_NONE, 2, 0},
        '{`SDAC_OP_WRITE, 21'h000020, 8'h03, `SDAC_ST_GOOD,  `SDAC_SK_NONE, 3, 3},
        '{`SDAC_OP_READ,  21'h000000, 8'h00, `SDAC_ST_GOOD,  `SDAC_SK_NONE, 256, 0},
        '{`SDAC_OP_WRITE, 21'h0000FF, 8'h01, `SDAC_ST_GOOD,  `SDAC_SK_NONE, 1, 1},
        '{`SDAC_OP_SEEK,  21'h000005, 8'h00, `SDAC_ST_GOOD,  `SDAC_SK_NONE, 0, 0},
        '{`SDAC_OP_WRITE, 21'h0000FF, 8'h02, `SDAC_ST_CHECK, `SDAC_SK_ILLEGAL, 0, 0},
        '{`SDAC_OP_SEEK,  21'h000100, 8'h00, `SDAC_ST_CHECK, `SDAC_SK_ILLEGAL, 0, 0},
        '{`SDAC_OP_READ,  21'h000200, 8'h01, `SDAC_ST_CHECK, `SDAC_SK_ILLEGAL, 0, 0},
        '{8'h00,          21'h000000, 8'h01, `SDAC_ST_CHECK, `SDAC_SK_ILLEGAL, 0, 0}};

    sdac_decode dut (.core_clk_i(clk), .srst_i(srst), .cmd_valid_i(cv), .cmd_byte_i(cb),
        .resv_conflict_i(rc), .unit_attn_i(ua), .rd_err_i(err[1]), .rd_recov_i(err[0]),
        .abort_i(err[2]), .dout_valid_i(dv), .dout_byte_i(db), .dout_ready_o(rdy),
        .blk_done_i(bd), .blk_o(blk), .stat_valid_o(sv), .stat_byte_o(sb), .linked_o(lk),
        .flag_o(fl), .stat_ack_i(ack), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat));
    sdac_media_model #(.DELAY(2)) media (.core_clk_i(clk), .clr_i(clr), .blk_i(blk),
        .blk_done_o(bd), .n_blk_o(nb), .n_wr_o(nw), .first_lba_o(flba), .last_lba_o(llba));

    always #2.5 clk = ~clk;
    // hang guard; the longest case runs about 1300 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
            n_mismatch++;
        end
    endtask : chk
    // six bytes: unit number and address top share byte 1, control last
    task automatic send_cmd(input logic [7:0] op, input logic [20:0] a, input logic [7:0] ln,
                            input logic [7:0] ctl);
        logic [7:0] b [6];
        b = '{op, {3'h0, a[20:16]}, a[15:8], a[7:0], ln, ctl};
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        for (int j = 0; j < 6; j++) begin
            @(posedge clk);
            cv <= 1'b1;
            cb <= b[j];
        end
        @(posedge clk) cv <= 1'b0;
    endtask : send_cmd
    // status is a one-cycle pulse, looked at once each cycle
    task automatic wait_stat(output logic [7:0] st);
        int j;
        for (j = 0; j < 2000; j++) begin
            @(posedge clk);
            #1;
            if (sv === 1'b1) break;
        end
        if (j == 2000) chk(32'h1, 32'h0, "no status");
        st = sb;
        @(posedge clk) ack <= 1'b1;
        @(posedge clk) ack <= 1'b0;
    endtask : wait_stat
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] q);
        @(posedge clk);
        rd <= 1'b1;
        ra <= a;
        @(posedge clk) rd <= 1'b0;
        #1 q = rdat;
    endtask : reg_rd
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        ra <= a;
        wd <= v;
        @(posedge clk) wr <= 1'b0;
    endtask : reg_wr
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        reg_rd(`SDAC_ADDR_CAPACITY, d);
        chk(d, 32'h100, "capacity reset");
        // table of ordinary commands
        foreach (rows[r]) begin
            send_cmd(rows[r].op, rows[r].lba, rows[r].len, 8'h00);
            wait_stat(s);
            chk(s, rows[r].st, "status");
            reg_rd(`SDAC_ADDR_SENSE, d);
            chk(d, rows[r].sk, "sense key");
            chk(nb, rows[r].nb, "block count");
            chk(nw, rows[r].nw, "write count");
            if (rows[r].nb > 0) chk(flba, rows[r].lba, "first lba");
            if (rows[r].nb > 0) chk(llba, rows[r].lba + rows[r].nb - 1, "last");
            $display("row %0d done", r);
        end
        reg_rd(`SDAC_ADDR_INFO, d);
        chk(d, 32'h200, "info lba");
        // reservation conflict for read then write
        @(posedge clk) rc <= 1'b1;
        for (int j = 0; j < 2; j++) begin
            send_cmd(j ? `SDAC_OP_WRITE : `SDAC_OP_READ, 21'h1, 8'h01, 8'h00);
            wait_stat(s);
            chk(s, `SDAC_ST_RESV, "conflict");
            chk(nb, 0, "conflict moved data");
        end
        rc <= 1'b0;
        $display("conflict done");
        // errors in mid transfer: abort, medium, recovered
        for (int j = 0; j < 3; j++) begin
            send_cmd(`SDAC_OP_READ, 21'h0, 8'h08, 8'h00);
            for (k = 0; k < 50 && blk.valid !== 1'b1; k++) @(posedge clk);
            err <= 3'h4 >> j;
            @(posedge clk) err <= 3'h0;
            wait_stat(s);
            chk(s, `SDAC_ST_CHECK, "error status");
            reg_rd(`SDAC_ADDR_SENSE, d);
            chk(d, j == 0 ? `SDAC_SK_ABORTED : j == 1 ? `SDAC_SK_MEDIUM : `SDAC_SK_RECOVERED,
                "error key");
        end
        $display("errors done");
        // unit attention pulse, then a write that reports it
        @(posedge clk) ua <= 1'b1;
        @(posedge clk) ua <= 1'b0;
        send_cmd(`SDAC_OP_WRITE, 21'h0, 8'h01, 8'h00);
        wait_stat(s);
        reg_rd(`SDAC_ADDR_SENSE, d);
        chk(d, `SDAC_SK_UNIT_ATTN, "attention key");
        chk(nw, 0, "attention wrote");
        // mode select with header and one descriptor, no vendor bytes; link and flag set
        send_cmd(`SDAC_OP_MSEL, 21'h0, 8'd12, 8'h03);
        i = 0;
        for (k = 0; i < 12 && k < 100; k++) begin
            @(posedge clk);
            dv <= 1'b1;
            db <= pl[i];
            @(negedge clk);
            if (rdy === 1'b1) i++;
        end
        @(posedge clk) dv <= 1'b0;
        wait_stat(s);
        chk(s, `SDAC_ST_GOOD, "select status");
        chk({lk, fl}, 2'h3, "link flag");
        chk(rdy, 1'b0, "ready after list");
        reg_rd(`SDAC_ADDR_MODE, d);
        chk(d, 32'h0800, "mode header");
        send_cmd(`SDAC_OP_MSEL, 21'h0, 8'h00, 8'h00);
        wait_stat(s);
        chk(s, `SDAC_ST_GOOD, "empty select");
        $display("mode select done");
        // smaller capacity, unmapped place, boundary address, then reset again
        reg_wr(`SDAC_ADDR_CAPACITY, 32'h40);
        reg_rd(`SDAC_ADDR_CAPACITY, d);
        chk(d, 32'h40, "capacity write");
        reg_rd(4'hF, d);
        chk(d, 32'h0, "unmapped read");
        send_cmd(`SDAC_OP_READ, 21'h3F, 8'h02, 8'h00);
        wait_stat(s);
        reg_rd(`SDAC_ADDR_INFO, d);
        chk(d, 32'h40, "first invalid");
        @(posedge clk) srst <= 1'b1;
        @(posedge clk) srst <= 1'b0;
        reg_rd(`SDAC_ADDR_CAPACITY, d);
        chk(d, 32'h100, "capacity after reset");
        send_cmd(`SDAC_OP_SEEK, 21'h0, 8'h00, 8'h00);
        wait_stat(s);
        chk(s, `SDAC_ST_CHECK, "attention after reset");
        $display("reset done");
        end_of_test();
    end
endmodule : test_scsi_direct_access_cmd_decode
`default_nettype wire
